//--- common/dma_pkg.sv
/*
  Constants, types and helpers shared by the multichannel transfer engine.
  Assumes one clock domain and a classic Wishbone register slave.
*/
package dma_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCH  = 2;
  localparam int CH_W = 1;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, channel stride 0x20)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CUR_SRC = 8'h04;
  localparam logic [7:0] OFF_REL_SRC = 8'h08;
  localparam logic [7:0] OFF_CUR_DST = 8'h0c;
  localparam logic [7:0] OFF_REL_DST = 8'h10;
  localparam logic [7:0] OFF_CUR_CNT = 8'h14;
  localparam logic [7:0] OFF_REL_CNT = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h40;
  localparam logic [7:0] OFF_MASK    = 8'h44;
  localparam int         CH_SEL_BIT  = 5;
  localparam int         GLOBAL_BIT  = 6;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int F_EN     = 0;
  localparam int F_REQ    = 1;
  localparam int F_RSEL   = 2;
  localparam int F_SIZE   = 4;
  localparam int F_PER_OPERAND_QUANTITY_SELECT  = 6;
  localparam int F_EIE    = 9;
  localparam int F_BURST  = 10;
  localparam int F_BRL    = 11;
  localparam int F_SRL    = 12;
  localparam int F_DRL    = 13;
  localparam int F_ECLR   = 14;
  localparam int F_STSCLR = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam int EXT_BIT = 31;

  // ----------------------------------------------------------------
  // Cycle counts per unit
  // ----------------------------------------------------------------
  localparam logic [1:0] RD_INT = 2'h1;
  localparam logic [1:0] RD_EXT = 2'h2;
  localparam logic [1:0] WR_INT = 2'h1;
  localparam logic [1:0] WR_EXT = 2'h3;
  localparam logic [1:0] GAP_II = 2'h0;
  localparam logic [1:0] GAP_IE = 2'h1;
  localparam logic [1:0] GAP_EX = 2'h2;

  typedef enum logic [3:0] {
    SQ_IDLE  = 4'h1,
    SQ_READ  = 4'h2,
    SQ_GAP   = 4'h4,
    SQ_WRITE = 4'h8
  } seq_state_type;

  typedef enum logic [1:0] {
    E_IDLE = 2'h1,
    E_WAIT = 2'h2
  } eng_state_type;

  // Bytes carried by one unit
  function automatic logic [31:0] unit_bytes(input logic [1:0] size);
    unit_bytes = (size == 2'h0) ? 32'h1 : ((size == 2'h1) ? 32'h2 : 32'h4);
  endfunction

  // Idle clocks between read and write
  function automatic logic [1:0] gap_clocks(input logic src_ext, input logic dst_ext);
    gap_clocks = src_ext ? GAP_EX : (dst_ext ? GAP_IE : GAP_II);
  endfunction
endpackage

//--- common/unit_if.sv
/*
  Hand-off of one transfer unit from the engine to the unit sequencer.
  Assumes both ends share the system clock.
*/
interface unit_if;
  logic        start;
  logic [31:0] src;
  logic [31:0] dst;
  logic [1:0]  size;
  logic        done;
  logic        busy;
  modport eng (output start, output src, output dst, output size, input done, input busy);
  modport seq (input start, input src, input dst, input size, output done, output busy);
endinterface

//--- logic/unit_sequencer.sv
/*
  Runs one unit: read clocks, idle clocks, write clocks, then a done pulse.
  Assumes read data is valid in the last read clock; address bit 31 marks external.
*/
module unit_sequencer
  import dma_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  unit_if.seq              u,
  input  wire logic [31:0] mem_rdata,
  output logic      [31:0] mem_addr,
  output logic             mem_re,
  output logic             mem_we,
  output logic      [31:0] mem_wdata,
  output logic      [1:0]  mem_size
);
  seq_state_type state_r;
  logic [1:0]    cnt_r;
  logic [1:0]    gap_len_r;
  logic [1:0]    wr_len_r;
  logic [31:0]   dst_r;
  logic [31:0]   data_r;
  logic          src_ext_r;
  logic          dst_ext_r;
  logic          done_r;
  logic          go_write;
  logic          last;

  assign last     = (cnt_r == 2'h0);
  assign go_write = (state_r == SQ_READ && last && gap_len_r == 2'h0) ||
                    (state_r == SQ_GAP && last);
  assign u.done   = done_r;
  assign u.busy   = (state_r != SQ_IDLE);

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= SQ_IDLE;
      cnt_r     <= 2'h0;
      gap_len_r <= 2'h0;
      wr_len_r  <= 2'h0;
      dst_r     <= WORD_RST;
      src_ext_r <= 1'b0;
      dst_ext_r <= 1'b0;
    end else begin
      case (state_r)
        SQ_IDLE: begin
          if (u.start) begin
            state_r   <= SQ_READ;
            cnt_r     <= (u.src[EXT_BIT] ? RD_EXT : RD_INT) - 2'h1;
            gap_len_r <= gap_clocks(u.src[EXT_BIT], u.dst[EXT_BIT]);
            wr_len_r  <= u.dst[EXT_BIT] ? WR_EXT : WR_INT;
            dst_r     <= u.dst;
            src_ext_r <= u.src[EXT_BIT];
            dst_ext_r <= u.dst[EXT_BIT];
          end
        end
        SQ_READ, SQ_GAP: begin
          if (go_write) begin
            state_r <= SQ_WRITE;
            cnt_r   <= wr_len_r - 2'h1;
          end else if (state_r == SQ_READ && last) begin
            state_r <= SQ_GAP;
            cnt_r   <= gap_len_r - 2'h1;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        SQ_WRITE: begin
          if (last) begin
            state_r <= SQ_IDLE;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: state_r <= SQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr  <= WORD_RST;
      mem_re    <= 1'b0;
      mem_we    <= 1'b0;
      mem_wdata <= WORD_RST;
      mem_size  <= 2'h0;
      data_r    <= WORD_RST;
      done_r    <= 1'b0;
    end else begin
      done_r <= (state_r == SQ_WRITE) && last;
      if (state_r == SQ_IDLE && u.start) begin
        mem_re   <= 1'b1;
        mem_addr <= u.src;
        mem_size <= u.size;
      end else if (state_r == SQ_READ && last) begin
        mem_re <= 1'b0;
        data_r <= mem_rdata;
      end
      if (go_write) begin
        mem_we    <= 1'b1;
        mem_addr  <= dst_r;
        mem_wdata <= (state_r == SQ_READ) ? mem_rdata : data_r;
      end else if (state_r == SQ_WRITE && last) begin
        mem_we <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rd_int;
    @(posedge clk) disable iff (!rst_n) $rose(mem_re) && !mem_addr[EXT_BIT] |=> !mem_re;
  endproperty
  a_rd_int: assert property (p_rd_int) else $error("internal read not one clock");

  property p_rd_ext;
    @(posedge clk) disable iff (!rst_n)
      $rose(mem_re) && mem_addr[EXT_BIT] |=> mem_re ##1 !mem_re;
  endproperty
  a_rd_ext: assert property (p_rd_ext) else $error("external read not two clocks");

  sequence s_ext_write;
    mem_we [*3] ##1 !mem_we;
  endsequence
  property p_wr_ext;
    @(posedge clk) disable iff (!rst_n) $rose(mem_we) && mem_addr[EXT_BIT] |-> s_ext_write;
  endproperty
  a_wr_ext: assert property (p_wr_ext) else $error("external write not three clocks");

  property p_ii_nogap;
    @(posedge clk) disable iff (!rst_n)
      $fell(mem_re) && !src_ext_r && !dst_ext_r |-> mem_we ##1 (!mem_we && done_r);
  endproperty
  a_ii_nogap: assert property (p_ii_nogap) else $error("internal unit timing wrong");

  property p_ee_gap;
    @(posedge clk) disable iff (!rst_n)
      $fell(mem_re) && src_ext_r && dst_ext_r |-> !mem_we ##1 !mem_we ##1 mem_we;
  endproperty
  a_ee_gap: assert property (p_ee_gap) else $error("external pair idle not two");
endmodule

//--- logic/dma_top.sv
/*
  Two channel transfer engine with Wishbone register slave and one IRQ.
  Assumes synchronous inputs and a memory port that answers with no waits.
*/
module dma_top
  import dma_pkg::*;
(
  input  wire logic             SYS_CLK,
  input  wire logic             RST_N,
  input  wire logic [7:0]       WB_ADR_I,
  input  wire logic [31:0]      WB_DAT_I,
  input  wire logic             WB_WE_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  output logic      [31:0]      WB_DAT_O,
  output logic                  WB_ACK_O,
  input  wire logic [NCH-1:0]   DMA_REQ,
  input  wire logic [31:0]      MEM_RDATA,
  output logic      [31:0]      MEM_ADDR,
  output logic                  MEM_RE,
  output logic                  MEM_WE,
  output logic      [31:0]      MEM_WDATA,
  output logic      [1:0]       MEM_SIZE,
  output logic                  IRQ
);
  logic [31:0]   ctrl_r [NCH];
  logic [31:0]   csrc_r [NCH];
  logic [31:0]   rsrc_r [NCH];
  logic [31:0]   cdst_r [NCH];
  logic [31:0]   rdst_r [NCH];
  logic [31:0]   ccnt_r [NCH];
  logic [31:0]   rcnt_r [NCH];
  logic [NCH-1:0] status_r;
  logic [NCH-1:0] mask_r;
  logic [NCH-1:0] en;
  logic [NCH-1:0] eie;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] end_vec;
  logic [NCH-1:0] req_bits;
  eng_state_type eng_r;
  logic [CH_W-1:0] act_r;
  logic [3:0]    op_left_r;
  logic          in_op_r;
  logic          start_r;
  logic [31:0]   bytes;
  logic [31:0]   cnt_after;
  logic          unit_done;
  logic          end_now;
  logic          wb_req;
  logic          wr_ev;
  logic          ch_hit;
  logic [CH_W-1:0] wch;
  logic [7:0]    woff;
  logic [31:0]   rd_mux;
  logic          stsclr;
  logic [31:0]   wmask;

  unit_if u ();

  // Byte-lane mask from select lines
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Lowest pending channel
  function automatic logic [CH_W-1:0] pick_lowest(input logic [NCH-1:0] v);
    pick_lowest = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_lowest = CH_W'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wb_req    = WB_CYC_I && WB_STB_I;
  assign wr_ev     = wb_req && WB_WE_I && WB_ACK_O;
  assign ch_hit    = !WB_ADR_I[GLOBAL_BIT];
  assign wch       = WB_ADR_I[CH_SEL_BIT];
  assign woff      = {3'h0, WB_ADR_I[4:0]};
  assign wmask     = lane_mask(WB_SEL_I);
  assign stsclr    = wr_ev && ch_hit && woff == OFF_CTRL && WB_SEL_I[1] && WB_DAT_I[F_STSCLR];
  assign bytes     = unit_bytes(ctrl_r[act_r][F_SIZE +: 2]);
  assign cnt_after = ccnt_r[act_r] - bytes;
  assign unit_done = (eng_r == E_WAIT) && u.done;
  assign end_now   = unit_done && (cnt_after == WORD_RST);
  assign pend      = en & req_bits;
  assign u.start   = start_r;
  assign u.src     = csrc_r[act_r];
  assign u.dst     = cdst_r[act_r];
  assign u.size    = ctrl_r[act_r][F_SIZE +: 2];

  always_comb begin
    rd_mux = WORD_RST;
    if (ch_hit) begin
      case (woff)
        OFF_CTRL:    rd_mux = ctrl_r[wch];
        OFF_CUR_SRC: rd_mux = csrc_r[wch];
        OFF_REL_SRC: rd_mux = rsrc_r[wch];
        OFF_CUR_DST: rd_mux = cdst_r[wch];
        OFF_REL_DST: rd_mux = rdst_r[wch];
        OFF_CUR_CNT: rd_mux = ccnt_r[wch];
        OFF_REL_CNT: rd_mux = rcnt_r[wch];
        default:     rd_mux = WORD_RST;
      endcase
    end else if (WB_ADR_I == OFF_STATUS) begin
      rd_mux = {{(32-NCH){1'b0}}, status_r};
    end else if (WB_ADR_I == OFF_MASK) begin
      rd_mux = {{(32-NCH){1'b0}}, mask_r};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= WORD_RST;
    end else begin
      WB_ACK_O <= wb_req && !WB_ACK_O;
      if (wb_req && !WB_ACK_O) begin
        WB_DAT_O <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign en[c]      = ctrl_r[c][F_EN];
      assign eie[c]     = ctrl_r[c][F_EIE];
      assign end_vec[c] = end_now && (act_r == CH_W'(c));
      assign req_bits[c] = ctrl_r[c][F_REQ];

      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          ctrl_r[c] <= CTRL_RST;
          csrc_r[c] <= WORD_RST;
          rsrc_r[c] <= WORD_RST;
          cdst_r[c] <= WORD_RST;
          rdst_r[c] <= WORD_RST;
          ccnt_r[c] <= WORD_RST;
          rcnt_r[c] <= WORD_RST;
        end else begin
          if (unit_done && act_r == CH_W'(c)) begin
            csrc_r[c] <= csrc_r[c] + bytes;
            cdst_r[c] <= cdst_r[c] + bytes;
            ccnt_r[c] <= cnt_after;
            if (end_now) begin
              ctrl_r[c][F_REQ] <= 1'b0;
              if (ctrl_r[c][F_BRL]) ccnt_r[c] <= rcnt_r[c];
              if (ctrl_r[c][F_SRL]) csrc_r[c] <= rsrc_r[c];
              if (ctrl_r[c][F_DRL]) cdst_r[c] <= rdst_r[c];
              if (ctrl_r[c][F_ECLR]) ctrl_r[c][F_EN] <= 1'b0;
            end else if (op_left_r == 4'h1 && !ctrl_r[c][F_BURST]) begin
              ctrl_r[c][F_REQ] <= 1'b0;
            end
          end
          if (wr_ev && ch_hit && wch == CH_W'(c)) begin
            case (woff)
              OFF_CTRL: begin
                ctrl_r[c] <= ((ctrl_r[c] & ~wmask) | (WB_DAT_I & wmask)) &
                             ~(32'h1 << F_STSCLR);
              end
              OFF_CUR_SRC: csrc_r[c] <= (csrc_r[c] & ~wmask) | (WB_DAT_I & wmask);
              OFF_REL_SRC: rsrc_r[c] <= (rsrc_r[c] & ~wmask) | (WB_DAT_I & wmask);
              OFF_CUR_DST: cdst_r[c] <= (cdst_r[c] & ~wmask) | (WB_DAT_I & wmask);
              OFF_REL_DST: rdst_r[c] <= (rdst_r[c] & ~wmask) | (WB_DAT_I & wmask);
              OFF_CUR_CNT: ccnt_r[c] <= (ccnt_r[c] & ~wmask) | (WB_DAT_I & wmask);
              OFF_REL_CNT: rcnt_r[c] <= (rcnt_r[c] & ~wmask) | (WB_DAT_I & wmask);
              default: ;
            endcase
          end
          if (ctrl_r[c][F_RSEL +: 2] != 2'h0 && DMA_REQ[c]) begin
            ctrl_r[c][F_REQ] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Operand engine
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eng_r     <= E_IDLE;
      act_r     <= '0;
      op_left_r <= 4'h0;
      in_op_r   <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (eng_r)
        E_IDLE: begin
          if (stsclr) begin
            in_op_r <= 1'b0;
          end else if (in_op_r) begin
            if (en[act_r]) begin
              start_r <= 1'b1;
              eng_r   <= E_WAIT;
            end
          end else if (|pend) begin
            act_r     <= pick_lowest(pend);
            op_left_r <= {1'b0, ctrl_r[pick_lowest(pend)][F_PER_OPERAND_QUANTITY_SELECT +: 3]} + 4'h1;
            in_op_r   <= 1'b1;
            start_r   <= 1'b1;
            eng_r     <= E_WAIT;
          end
        end
        E_WAIT: begin
          if (u.done) begin
            eng_r     <= E_IDLE;
            op_left_r <= op_left_r - 4'h1;
            if (end_now || op_left_r == 4'h1) begin
              in_op_r <= 1'b0;
            end
          end
        end
        default: eng_r <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // End flags and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= '0;
      mask_r   <= '0;
      IRQ      <= 1'b0;
    end else begin
      if (wr_ev && WB_ADR_I == OFF_MASK) begin
        mask_r <= WB_DAT_I[NCH-1:0];
      end
      if (wr_ev && WB_ADR_I == OFF_STATUS) begin
        status_r <= (status_r & ~WB_DAT_I[NCH-1:0]) | end_vec;
      end else begin
        status_r <= status_r | end_vec;
      end
      IRQ <= |(status_r & mask_r & eie);
    end
  end

  unit_sequencer u_seq (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .u         (u),
    .mem_rdata (MEM_RDATA),
    .mem_addr  (MEM_ADDR),
    .mem_re    (MEM_RE),
    .mem_we    (MEM_WE),
    .mem_wdata (MEM_WDATA),
    .mem_size  (MEM_SIZE)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_end_flag;
    @(posedge SYS_CLK) disable iff (!RST_N)
      end_vec != '0 |=> ((status_r & $past(end_vec)) == $past(end_vec));
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag not set");

  property p_irq;
    @(posedge SYS_CLK) disable iff (!RST_N) |(status_r & mask_r & eie) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_no_start_disabled;
    @(posedge SYS_CLK) disable iff (!RST_N) start_r |-> $past(en[act_r]) || $past(pend != '0);
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("disabled start");

  property p_stsclr;
    @(posedge SYS_CLK) disable iff (!RST_N) stsclr && eng_r == E_IDLE |=> !in_op_r && !start_r;
  endproperty
  a_stsclr: assert property (p_stsclr) else $error("status clear did not abort");

  sequence s_halted;
    eng_r == E_IDLE && in_op_r && !en[act_r];
  endsequence
  property p_resume;
    @(posedge SYS_CLK) disable iff (!RST_N)
      s_halted ##1 (en[act_r] && !stsclr) |=> start_r;
  endproperty
  a_resume: assert property (p_resume) else $error("halted operand not resumed");
endmodule

//--- bench/mem_model.sv
/*
  Zero-wait memory standing on the transfer port, internal and external alike.
  Assumes the engine drives address and strobes from registers on SYS_CLK.
*/
module mem_model (
  input  wire logic        clk,
  input  wire logic [31:0] addr,
  input  wire logic        re,
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:15];
  logic [31:0] last_r = 32'h0;

  initial for (int i = 0; i < 16; i++) mem[i] = 32'ha5a5_0000 + i;

  // ----------------------------------------------------------------
  // Read data only while read strobe is high
  // ----------------------------------------------------------------
  assign rdata = re ? mem[addr[5:2]] : ~last_r;

  always @(posedge clk) begin
    if (re) last_r <= mem[addr[5:2]];
    if (we) mem[addr[5:2]] <= wdata;
  end
endmodule

//--- bench/dma_top_tb_top.sv
/*
  Self-checking bench for the transfer engine, registers over Wishbone.
  Assumes the memory model answers with no waits.
*/
module dma_top_tb_top;
  import dma_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_dat  = 32'h0;
  logic        wb_we   = 1'b0;
  logic [3:0]  wb_sel  = 4'h0;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        clr     = 1'b0;
  logic [1:0]  dma_req = 2'h0;
  logic        rd_seen = 1'b0;
  wire logic [31:0] wb_rdat, mem_addr, mem_rdata, mem_wdata;
  wire logic        wb_ack, mem_re, mem_we, irq;
  wire logic [1:0]  mem_size;
  int errors = 0, total_checks = 0, cycles = 0, re_n = 0, we_n = 0, idle_n = 0;

  always #25 sys_clk = ~sys_clk;

  dma_top DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat),
    .WB_WE_I(wb_we), .WB_SEL_I(wb_sel), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .DMA_REQ(dma_req), .MEM_RDATA(mem_rdata),
    .MEM_ADDR(mem_addr), .MEM_RE(mem_re), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
    .MEM_SIZE(mem_size), .IRQ(irq));

  mem_model mem (.clk(sys_clk), .addr(mem_addr), .re(mem_re), .we(mem_we),
    .wdata(mem_wdata), .rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Strobe counters and timeout
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  always @(negedge sys_clk) begin
    if (clr) begin
      re_n <= 0; we_n <= 0; idle_n <= 0; rd_seen <= 1'b0;
    end else begin
      re_n <= re_n + int'(mem_re);
      we_n <= we_n + int'(mem_we);
      if (mem_re) rd_seen <= 1'b1;
      else if (mem_we) rd_seen <= 1'b0;
      else if (rd_seen) idle_n <= idle_n + 1;
    end
  end

  task automatic complete_run();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_adr <= a; wb_we <= w; wb_dat <= d; wb_sel <= 4'hf; wb_cyc <= 1'b1; wb_stb <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    if (wb_ack !== 1'b1) chk(32'h1, 32'h0);
    q = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask

  task automatic setup(input logic [31:0] src, input logic [31:0] dst, input logic [31:0] cnt);
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    wb_wr(8'h00, 32'h0);
    wb_wr(8'h04, src);
    wb_wr(8'h0c, dst);
    wb_wr(8'h14, cnt);
  endtask

  task automatic wait_end();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb_cycle(8'h40, 1'b0, 32'h0, q);
      n++;
    end while (q[0] !== 1'b1 && n < 200);
    chk(q, 32'h1);
  endtask

  task automatic run(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
                     input logic [1:0] sz, input int re_e, input int we_e, input int id_e);
    setup(s, d, c);
    wb_wr(8'h00, 32'h0000_0603 | {26'h0, sz, 4'h0});
    wait_end();
    chk(re_n, re_e);
    chk(we_n, we_e);
    chk(idle_n, id_e);
    chk({30'h0, mem_size}, {30'h0, sz});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    wb_cycle(8'h00, 1'b0, 32'h0, q); chk(q, CTRL_RST);
    wb_cycle(8'h1c, 1'b0, 32'h0, q); chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_int_int();
    wb_wr(8'h44, 32'h1);
    run(32'h0, 32'h10, 32'h8, 2'h2, 2, 2, 0);
    chk(mem.mem[4], 32'ha5a5_0000);
    chk(mem.mem[5], 32'ha5a5_0001);
    chk({31'h0, irq}, 32'h1);
    wb_wr(8'h40, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_ext();
    run(32'h0, 32'h8000_0020, 32'h4, 2'h1, 2, 6, 2);
    wb_wr(8'h40, 32'h1);
    run(32'h8000_0000, 32'h8000_0030, 32'h4, 2'h1, 4, 6, 4);
    wb_wr(8'h40, 32'h1);
  endtask

  task automatic t_disabled();
    logic [31:0] q;
    setup(32'h0, 32'h18, 32'h4);
    wb_wr(8'h00, 32'h0000_0622);
    repeat (20) @(posedge sys_clk);
    chk(re_n, 0);
    wb_wr(8'h00, 32'h0000_0623);
    wait_end();
    chk(we_n, 1);
    wb_wr(8'h00, 32'h0);
    wb_wr(8'h20, 32'h0000_8000);
    wb_cycle(8'h20, 1'b0, 32'h0, q); chk(q, 32'h0);
  endtask

  task automatic t_halt();
    wb_wr(8'h40, 32'h3);
    setup(32'h0, 32'h20, 32'h10);
    wb_wr(8'h00, 32'h0000_00e3);
    wb_wr(8'h00, 32'h0000_00e2);
    repeat (10) @(posedge sys_clk);
    chk(we_n, 1);
    wb_wr(8'h00, 32'h0000_00e3);
    wait_end();
    chk(we_n, 4);
    chk(mem.mem[11], 32'ha5a5_0003);
    wb_wr(8'h40, 32'h1);
    setup(32'h0, 32'h20, 32'h10);
    wb_wr(8'h00, 32'h0000_00e3);
    wb_wr(8'h00, 32'h0000_00e2);
    repeat (4) @(posedge sys_clk);
    wb_wr(8'h20, 32'h0000_8000);
    wb_wr(8'h00, 32'h0000_00e1);
    repeat (20) @(posedge sys_clk);
    chk(we_n, 1);
    wb_wr(8'h00, 32'h0);
  endtask

  task automatic t_hw_req();
    wb_wr(8'h40, 32'h1);
    setup(32'h0, 32'h1c, 32'h4);
    wb_wr(8'h00, 32'h0000_0425);
    repeat (10) @(posedge sys_clk);
    chk(re_n, 0);
    @(posedge sys_clk) dma_req <= 2'h1;
    @(posedge sys_clk) dma_req <= 2'h0;
    wait_end();
    chk(we_n, 1);
    chk(mem.mem[7], 32'ha5a5_0000);
    wb_wr(8'h00, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_int_int();
    t_ext();
    t_disabled();
    t_halt();
    t_hw_req();
    complete_run();
  end
endmodule
